// ---- design/misc_cfg_regs.sv ----
`timescale 1ns/1ps
`include "misc_cfg_map.svh"

// Function
// - bit 7 powers down unused circuitry
// - power register writable only when enabled
// - bit 7 forces carrier detect
// - carrier register writable only when enabled
// - lock count resets to 0x64
// - identifier bits 31:30 read zero
// - identifier readable only with read enable
// - identifier is read-only

module misc_cfg_regs
  import misc_cfg_pkg::*;
#(
  parameter int ID_BITS = `CHIP_ID_BITS
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire apb_req_s apb_req,
  output apb_rsp_s apb_rsp,
  input wire logic [ID_BITS-1:0] chip_id_value,
  input wire logic carrier_sensed,
  output logic power_save_en,
  output logic carrier_present,
  output logic cfg_write_en,
  output logic id_sense_en,
  output logic [7:0] clk_override,
  output logic [7:0] clk_enable,
  output logic [7:0] synth_lock_count
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] analog_ctrl_reg;
  logic [7:0] analog_ctrl_next;
  logic [7:0] power_save_reg;
  logic [7:0] power_save_next;
  logic [7:0] carrier_detect_reg;
  logic [7:0] carrier_detect_next;
  logic [7:0] clk_override_reg;
  logic [7:0] clk_override_next;
  logic [7:0] clk_enable_reg;
  logic [7:0] clk_enable_next;
  logic [7:0] synth_lock_reg;
  logic [7:0] synth_lock_next;
  apb_phase_e phase_reg;
  apb_phase_e phase_next;
  apb_rsp_s rsp_reg;
  apb_rsp_s rsp_next;
  logic carrier_reg;
  logic carrier_next;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire logic [5:0] word_idx = apb_req.paddr[7:2];
  wire logic addr_aligned = (apb_req.paddr[1:0] == 2'b00);
  wire logic access = apb_req.psel && apb_req.penable && (phase_reg == PH_WAIT);
  wire logic wr_lane0 = apb_req.pwrite && apb_req.pstrb[0];
  wire logic [7:0] idx8 = {2'b00, word_idx};

  wire logic hit_analog = addr_aligned && (idx8 == `IDX_ANALOG_CTRL);
  wire logic hit_power = addr_aligned && (idx8 == `IDX_POWER_SAVE);
  wire logic hit_carrier = addr_aligned && (idx8 == `IDX_CARRIER_DETECT);
  wire logic hit_clk_ovr = addr_aligned && (idx8 == `IDX_CLK_OVERRIDE);
  wire logic hit_clk_en = addr_aligned && (idx8 == `IDX_CLK_ENABLE);
  wire logic hit_synth = addr_aligned && (idx8 == `IDX_SYNTH_LOCK);
  wire logic hit_id = addr_aligned && (idx8 >= `IDX_CHIP_ID_B0)
    && (idx8 <= `IDX_CHIP_ID_B3);

  reg_sel_e sel;
  assign sel = hit_analog ? SEL_ANALOG :
               hit_power ? SEL_POWER :
               hit_carrier ? SEL_CARRIER :
               hit_clk_ovr ? SEL_CLK_OVR :
               hit_clk_en ? SEL_CLK_EN :
               hit_synth ? SEL_SYNTH :
               hit_id ? SEL_CHIP_ID : SEL_NONE;

  wire logic gated_ok = analog_ctrl_reg[`BIT_CFG_WRITE_EN];
  wire logic id_read_en = analog_ctrl_reg[`BIT_ID_READ_EN];
  // first access edge only, so a held request stores once
  wire logic do_write = access && wr_lane0;

  ////////////////////////////////////////////////////////////////////////////
  // write strobes

  wire logic wr_analog = do_write && (sel == SEL_ANALOG);
  wire logic wr_power = do_write && (sel == SEL_POWER) && gated_ok;
  wire logic wr_carrier = do_write && (sel == SEL_CARRIER) && gated_ok;
  wire logic wr_clk_ovr = do_write && (sel == SEL_CLK_OVR);
  wire logic wr_clk_en = do_write && (sel == SEL_CLK_EN);
  wire logic wr_synth = do_write && (sel == SEL_SYNTH);

  ////////////////////////////////////////////////////////////////////////////
  // identifier byte path

  logic [7:0] id_byte;

  chip_id_reader #(
    .ID_BITS(ID_BITS)
  ) u_chip_id (
    .id_value(chip_id_value),
    .read_en(id_read_en),
    .byte_sel(word_idx[1:0]),
    .id_byte(id_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write side

  assign analog_ctrl_next = wr_analog ?
    apb_req.pwdata[7:0] : analog_ctrl_reg;

  assign power_save_next = wr_power ?
    apb_req.pwdata[7:0] : power_save_reg;

  assign carrier_detect_next = wr_carrier ?
    apb_req.pwdata[7:0] : carrier_detect_reg;

  assign clk_override_next = wr_clk_ovr ?
    apb_req.pwdata[7:0] : clk_override_reg;

  assign clk_enable_next = wr_clk_en ?
    apb_req.pwdata[7:0] : clk_enable_reg;

  assign synth_lock_next = wr_synth ?
    apb_req.pwdata[7:0] : synth_lock_reg;

  assign carrier_next = carrier_detect_reg[`BIT_CD_OVERRIDE] | carrier_sensed;

  ////////////////////////////////////////////////////////////////////////////
  // read side and answer

  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = 8'h00;
    case (sel)
      SEL_ANALOG: rd_byte = analog_ctrl_reg;
      SEL_POWER: rd_byte = power_save_reg;
      SEL_CARRIER: rd_byte = carrier_detect_reg;
      SEL_CLK_OVR: rd_byte = clk_override_reg;
      SEL_CLK_EN: rd_byte = clk_enable_reg;
      SEL_SYNTH: rd_byte = synth_lock_reg;
      SEL_CHIP_ID: rd_byte = id_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  // identifier write: no store, no error
  wire logic rsp_err = (sel == SEL_NONE);
  wire logic [31:0] rsp_data = apb_req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};

  // one wait state keeps prdata registered; unmapped answers slverr
  always_comb
  begin
    phase_next = phase_reg;
    rsp_next = '0;
    case (phase_reg)
      PH_WAIT:
      begin
        if (access)
        begin
          phase_next = PH_DONE;
          rsp_next.pready = 1'b1;
          rsp_next.pslverr = rsp_err;
          rsp_next.prdata = rsp_data;
        end
      end
      PH_DONE:
      begin
        phase_next = PH_WAIT;
      end
      default:
      begin
        phase_next = PH_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flops

  // analog control: write and read gates
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_ctrl_reg <= `RST_ANALOG_CTRL;
    end
    else
    begin
      analog_ctrl_reg <= analog_ctrl_next;
    end
  end

  // power saving control
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_save_reg <= `RST_POWER_SAVE;
    end
    else
    begin
      power_save_reg <= power_save_next;
    end
  end

  // carrier detect override
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carrier_detect_reg <= `RST_CARRIER_DETECT;
    end
    else
    begin
      carrier_detect_reg <= carrier_detect_next;
    end
  end

  // manual clock override
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_override_reg <= `RST_CLK_OVERRIDE;
    end
    else
    begin
      clk_override_reg <= clk_override_next;
    end
  end

  // manual clock enable
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_enable_reg <= `RST_CLK_ENABLE;
    end
    else
    begin
      clk_enable_reg <= clk_enable_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synth_lock_reg <= `RST_SYNTH_LOCK;
    end
    else
    begin
      synth_lock_reg <= synth_lock_next;
    end
  end

  // answer phase blocks a second store on a held request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= PH_WAIT;
    end
    else
    begin
      phase_reg <= phase_next;
    end
  end

  // registered answer keeps the decode off the bus timing
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_reg <= '0;
    end
    else
    begin
      rsp_reg <= rsp_next;
    end
  end

  // one cycle of lag on carrier
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carrier_reg <= 1'b0;
    end
    else
    begin
      carrier_reg <= carrier_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign apb_rsp = rsp_reg;
  assign power_save_en = power_save_reg[`BIT_POWER_SAVE];
  assign carrier_present = carrier_reg;
  assign cfg_write_en = analog_ctrl_reg[`BIT_CFG_WRITE_EN];
  // identifier sense costs power, so it follows the enable bit only
  assign id_sense_en = analog_ctrl_reg[`BIT_ID_READ_EN];
  assign clk_override = clk_override_reg;
  assign clk_enable = clk_enable_reg;
  assign synth_lock_count = synth_lock_reg;

endmodule // misc_cfg_regs

// ---- common/misc_cfg_map.svh ----
`ifndef MISC_CFG_MAP_SVH
`define MISC_CFG_MAP_SVH

// register indices; byte address is four times the index
`define IDX_ANALOG_CTRL 8'h20
`define IDX_POWER_SAVE 8'h2E
`define IDX_CARRIER_DETECT 8'h2F
`define IDX_CLK_OVERRIDE 8'h32
`define IDX_CLK_ENABLE 8'h33
`define IDX_SYNTH_LOCK 8'h38
`define IDX_CHIP_ID_B0 8'h3C
`define IDX_CHIP_ID_B3 8'h3F

// field positions
`define BIT_POWER_SAVE 7
`define BIT_CD_OVERRIDE 7
`define BIT_CFG_WRITE_EN 6
`define BIT_ID_READ_EN 5

// reset values
`define RST_ANALOG_CTRL 8'h00
`define RST_POWER_SAVE 8'h00
`define RST_CARRIER_DETECT 8'h00
`define RST_CLK_OVERRIDE 8'h00
`define RST_CLK_ENABLE 8'h00
`define RST_SYNTH_LOCK 8'h64

// identifier layout
`define CHIP_ID_BITS 30
`define CHIP_ID_BYTES 4

// slave answers one cycle into the access phase
`define APB_WAIT_CYCLES 1

`endif

// ---- common/misc_cfg_pkg.sv ----
package misc_cfg_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_ANALOG,
    SEL_POWER,
    SEL_CARRIER,
    SEL_CLK_OVR,
    SEL_CLK_EN,
    SEL_SYNTH,
    SEL_CHIP_ID
  } reg_sel_e;

  typedef enum logic {
    PH_WAIT,
    PH_DONE
  } apb_phase_e;

endpackage

// ---- design/chip_id_reader.sv ----
`timescale 1ns/1ps
`include "misc_cfg_map.svh"

module chip_id_reader
  import misc_cfg_pkg::*;
#(
  parameter int ID_BITS = `CHIP_ID_BITS
)
(
  input wire logic [ID_BITS-1:0] id_value,
  input wire logic read_en,
  input wire logic [1:0] byte_sel,
  output logic [7:0] id_byte
);

  logic [31:0] id_word;
  logic [7:0] lanes [`CHIP_ID_BYTES];

  assign id_word = {{(32-ID_BITS){1'b0}}, id_value};

  genvar g;
  generate
    for (g = 0; g < `CHIP_ID_BYTES; g++)
    begin : g_lane
      assign lanes[g] = read_en ? id_word[g*8 +: 8] : 8'h00;
    end
  endgenerate

  assign id_byte = lanes[byte_sel];

endmodule // chip_id_reader

// ---- verif/misc_cfg_regs_sva.sv ----
`timescale 1ns/1ps
module misc_cfg_regs_chk
  import misc_cfg_pkg::*;
#(
  parameter int ID_BITS = 30
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire apb_req_s apb_req,
  input wire apb_rsp_s apb_rsp,
  input wire logic [ID_BITS-1:0] chip_id_value,
  input wire logic carrier_sensed,
  input wire logic power_save_en,
  input wire logic carrier_present,
  input wire logic cfg_write_en,
  input wire logic id_sense_en,
  input wire logic [7:0] synth_lock_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // first access edge only; pready marks the second
  wire take = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  wire rd = take && !apb_req.pwrite;
  wire is_id = apb_req.paddr[7:4] == 4'hf && apb_req.paddr[1:0] == 2'b00;
  wire pwr = take && apb_req.pwrite && apb_req.paddr == 8'hb8;
  wire [1:0] bsel = apb_req.paddr[3:2];
  wire [31:0] id_word = 32'(chip_id_value);
  ////////////////////////////////////////
  a_ready_one: assert property (take |=> apb_rsp.pready)
    else $error("ready not one cycle after access");
  a_lock_reset: assert property ($rose(rst_n) |-> synth_lock_count == 8'h64)
    else $error("lock count reset value");
  a_power_write: assert property (pwr && apb_req.pstrb[0] && cfg_write_en
    |=> power_save_en == $past(apb_req.pwdata[7])) else $error("power bit not stored");
  a_power_gated: assert property (pwr && !cfg_write_en |=> $stable(power_save_en))
    else $error("power bit changed while gated");
  a_carrier_or: assert property (carrier_sensed |=> carrier_present)
    else $error("carrier not passed");
  a_id_hidden: assert property (rd && is_id && !id_sense_en |=> apb_rsp.prdata == 0)
    else $error("identifier visible while disabled");
  a_id_byte: assert property (rd && is_id && id_sense_en
    |=> apb_rsp.prdata == {24'h0, id_word[8*$past(bsel) +: 8]}) else $error("id byte");
  a_id_top: assert property (rd && apb_req.paddr == 8'hfc |=> apb_rsp.prdata[7:6] == 0)
    else $error("identifier top bits set");
  a_id_readonly: assert property (take && apb_req.pwrite && is_id
    |=> !apb_rsp.pslverr) else $error("identifier write errored");
endmodule // misc_cfg_regs_chk

bind misc_cfg_regs misc_cfg_regs_chk #(.ID_BITS(ID_BITS)) chk (.core_clk, .rst_n, .apb_req,
  .apb_rsp, .chip_id_value, .carrier_sensed, .power_save_en, .carrier_present,
  .cfg_write_en, .id_sense_en, .synth_lock_count);

// ---- verif/radio_misc_config_registers_test.sv ----
`timescale 1ns/1ps
module radio_misc_config_registers_test
  import misc_cfg_pkg::*;
;
  logic core_clk = 0;
  logic rst_n = 0;
  logic carrier_sensed = 0;
  logic [29:0] chip_id_value = 30'h0;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  logic power_save_en, carrier_present, cfg_write_en, id_sense_en;
  logic [7:0] clk_override, clk_enable, synth_lock_count;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'd46;
  logic [31:0] r;
  logic [31:0] rd;
  logic err;
  logic [7:0] m [int];
  logic [7:0] tbl [12] = '{8'h80, 8'hb8, 8'hbc, 8'hc8, 8'hcc, 8'he0, 8'hf0, 8'hf4, 8'hf8,
    8'hfc, 8'h84, 8'h81};
  always #4 core_clk = ~core_clk;
  misc_cfg_regs dut (.core_clk, .rst_n, .apb_req, .apb_rsp, .chip_id_value, .carrier_sensed,
    .power_save_en, .carrier_present, .cfg_write_en, .id_sense_en, .clk_override,
    .clk_enable, .synth_lock_count);
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // holds the request until pready; extra idle edge avoids double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
    apb_req <= '{1'b1, 1'b0, w, a, {24'h0, d}, {3'b111, s}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
    logic [7:0] ix;
    logic [7:0] ex;
    logic [31:0] idw;
    logic ee;
    logic id;
    ix = a >> 2;
    idw = {2'b00, chip_id_value};
    id = ix >= 8'h3c;
    ee = a[1:0] != 0 || (!id && !m.exists(ix));
    ex = id ? (m[8'h20][5] ? idw[8*ix[1:0] +: 8] : 8'h0) : (ee ? 8'h0 : m[ix]);
    if (w && s && !ee && !id && (ix < 8'h2e || ix > 8'h2f || m[8'h20][6]))
      m[ix] = d;
    apb(w, a, d, s);
    check(err, ee);
    check(rd, w ? 32'h0 : {24'h0, ex});
    check(power_save_en, m[8'h2e][7]);
    check(carrier_present, carrier_sensed | m[8'h2f][7]);
    check({cfg_write_en, id_sense_en}, m[8'h20][6:5]);
    check({clk_override, clk_enable, synth_lock_count}, {m[8'h32], m[8'h33], m[8'h38]});
  endtask
  ////////////////////////////////////////
  initial
  begin
    chip_id_value <= 30'(rnd());
    m = '{8'h20: 8'h0, 8'h2e: 8'h0, 8'h2f: 8'h0, 8'h32: 8'h0, 8'h33: 8'h0, 8'h38: 8'h64};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 12; i++)
      op(0, tbl[i], 0, 1);
    op(1, 8'hb8, 8'h80, 1);
    op(1, 8'h80, 8'h40, 1);
    op(1, 8'hb8, 8'h80, 1);
    op(1, 8'hc8, 8'h41, 1);
    op(1, 8'hcc, 8'h41, 1);
    op(1, 8'h80, 8'h60, 1);
    for (int i = 6; i < 10; i++)
      op(0, tbl[i], 0, 1);
    op(1, 8'h80, 8'h40, 1);
    op(0, 8'hf0, 0, 1);
    // reserved bits of gated registers kept zero
    repeat (300)
    begin
      r = rnd();
      carrier_sensed <= r[8];
      op(r[0], tbl[r[7:4] % 12], r[31:24] & (r[7:4] % 12 inside {1, 2} ? 8'h80 : 8'hff),
        r[1]);
    end
    give_verdict();
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
endmodule // radio_misc_config_registers_test
